// [sim/rtc_lut_alarm_props.sv]
// assertion checker for the lookup table and alarm block
module rtc_lut_alarm_props #(
  parameter int LUT_DEPTH = 128,
  parameter int ADR_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rtc_lut_pkg::rtc_wb_req_t wb_req_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic signed [rtc_lut_pkg::RTC_TEMP_W-1:0] die_temp_reading_i,
  input wire logic temp_done_i,
  input wire rtc_lut_pkg::rtc_time_t rtc_time_i,
  input wire logic [rtc_lut_pkg::RTC_RATE_W-1:0] rate_value_o,
  input wire logic rate_load_o,
  input wire logic second_tick_irq_o,
  input wire logic minute_tick_irq_o,
  input wire logic alarm_irq_o,
  input wire logic ext_int6_o
);
  import rtc_lut_pkg::*;
  logic rd_ack;
  logic [13:0] idx;
  assign rd_ack = wb_ack_o && !wb_req_i.we;
  assign idx = wb_req_i.adr[15:2];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_int6_or: assert property (ext_int6_o == (second_tick_irq_o || minute_tick_irq_o || alarm_irq_o))
    else $error("shared line differs from event sources");
  a_sec_pulse: assert property (second_tick_irq_o |=> !second_tick_irq_o)
    else $error("second event longer than one cycle");
  a_alarm_pulse: assert property (alarm_irq_o |=> !alarm_irq_o)
    else $error("alarm event longer than one cycle");
  a_rate_range: assert property (rate_load_o |-> rate_value_o >= 19'h3ff80 && rate_value_o <= 19'h4007f)
    else $error("loaded rate outside signed byte range");
  a_rate_hold: assert property (!rate_load_o |-> rate_value_o == $past(rate_value_o))
    else $error("rate changed without a load");
  a_min_width: assert property (rd_ack && idx == RTC_IDX_ALM_MIN |-> wb_dat_o[31:6] == '0)
    else $error("target minutes wider than six bits");
  a_hr_width: assert property (rd_ack && idx == RTC_IDX_ALM_HR |-> wb_dat_o[31:5] == '0)
    else $error("target hours wider than five bits");
  a_sec_tick: assert property ($changed(rtc_time_i.sec_toggle) |-> ##[3:8] second_tick_irq_o)
    else $error("second toggle gave no event");
  a_min_tick: assert property ($changed(rtc_time_i.min_toggle) |-> ##[3:8] minute_tick_irq_o)
    else $error("minute toggle gave no event");
endmodule

bind rtc_lut_alarm rtc_lut_alarm_props #(.LUT_DEPTH(LUT_DEPTH), .ADR_W(ADR_W)) rtc_lut_alarm_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .die_temp_reading_i(die_temp_reading_i), .temp_done_i(temp_done_i), .rtc_time_i(rtc_time_i),
  .rate_value_o(rate_value_o), .rate_load_o(rate_load_o), .second_tick_irq_o(second_tick_irq_o),
  .minute_tick_irq_o(minute_tick_irq_o), .alarm_irq_o(alarm_irq_o), .ext_int6_o(ext_int6_o));

// [sim/rtc_lut_alarm_tb.sv]
// self-checking bench for the lookup table and alarm block
module rtc_lut_alarm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_lut_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  rtc_wb_req_t wb = '0;
  logic ack, rload, s_irq, m_irq, a_irq, int6;
  logic [31:0] rdat;
  logic signed [10:0] temp = '0;
  logic tdone = 1'b0;
  rtc_time_t tm = '0;
  logic [18:0] rate, exp_rate;
  int fails = 0;
  int total_checks = 0;
  logic [32:0] rd_q[$];
  logic [18:0] rate_q[$];
  logic [3:0] irq_q[$];
  logic [7:0] tbl[128];
  logic signed [10:0] tc[6] = '{11'sh400, 11'sh3ff, 11'sh7fd, 11'sh005, 11'sh7fb, 11'sh0fd};

  rtc_lut_alarm #(.LUT_DEPTH(128), .ADR_W(16)) rtc_lut_alarm_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb), .wb_ack_o(ack), .wb_dat_o(rdat), .die_temp_reading_i(temp),
    .temp_done_i(tdone), .rtc_time_i(tm), .rate_value_o(rate), .rate_load_o(rload),
    .second_tick_irq_o(s_irq), .minute_tick_irq_o(m_irq), .alarm_irq_o(a_irq), .ext_int6_o(int6));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // entered just after a rising edge; holds the request until ack is sampled
  task automatic bus(input logic we, input logic [13:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (n >= 40) begin
      fails++;
      summarize();
    end
    wb <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] e);
    logic [31:0] q;
    rd_q.push_back({1'b1, e});
    bus(1'b0, idx, 32'h0, q);
  endtask

  // set a strobe, then poll until the device clears it
  task automatic lut_op(input bit rdop);
    logic [31:0] q;
    int n;
    bus(1'b1, RTC_IDX_LUT_STRB, rdop ? 32'h2 : 32'h1, q);
    n = 0;
    do begin
      rd_q.push_back({1'b1, n == 0 ? 32'h4 | (32'h1 << rdop) : 32'h0});
      bus(1'b0, RTC_IDX_LUT_STRB, 32'h0, q);
      n++;
    end while (q[rdop] !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      summarize();
    end
  endtask

  task automatic tw(input logic [6:0] a, input logic [7:0] v);
    wr(RTC_IDX_LUT_ADDR, {25'h0, a});
    wr(RTC_IDX_LUT_DATA, {24'h0, v});
    lut_op(1'b0);
    tbl[a] = v;
    rd(RTC_IDX_LUT_ADDR, {25'h0, a});
  endtask

  task automatic tmp(input logic signed [10:0] r, input bit e);
    int s;
    logic [6:0] a;
    s = int'(r) >>> 2;
    s = s < -64 ? -64 : (s > 63 ? 63 : s);
    a = 7'(s);
    exp_rate = e ? RTC_RATE_NOMINAL + {{11{tbl[a][7]}}, tbl[a]} : exp_rate;
    if (e) rate_q.push_back(exp_rate);
    temp <= r;
    tdone <= 1'b1;
    @(posedge clk_i);
    tdone <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic tick(input logic [3:0] e);
    irq_q.push_back(e);
    repeat (12) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // result watcher: each observed result consumes the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    logic [32:0] e;
    if (ack === 1'b1 && wb.we === 1'b0) begin
      e = rd_q.pop_front();
      if (e[32]) check("read", rdat, e[31:0]);
    end
    if (rload === 1'b1) check("rate", {13'h0, rate}, rate_q.size() != 0 ? rate_q.pop_front() : 'x);
    if ((int6 | s_irq | m_irq | a_irq) === 1'b1)
      check("irq", {int6, s_irq, m_irq, a_irq}, irq_q.size() != 0 ? irq_q.pop_front() : 'x);
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    fails++;
    summarize();
  end

  initial begin
    logic [5:0] tmin;
    logic [4:0] thr;
    void'($urandom(32'h5ea5));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(RTC_IDX_ALM_MIN, 32'h0);
    rd(RTC_IDX_ALM_HR, 32'h0);
    rd(RTC_IDX_LUT_ADDR, 32'h0);
    rd(RTC_IDX_RATE, 32'h40000);
    rd(14'h0100, 32'h0);
    wr(RTC_IDX_ALM_MIN, 32'hffffffff);
    rd(RTC_IDX_ALM_MIN, 32'h3f);
    wr(RTC_IDX_ALM_HR, 32'hffffffff);
    rd(RTC_IDX_ALM_HR, 32'h1f);
    // fill across the top of the table so the address wraps
    wr(RTC_IDX_LUT_ADDR, 32'hfe);
    for (int i = 0; i < 3; i++) begin
      tbl[7'(126 + i)] = 8'($urandom);
      wr(RTC_IDX_LUT_DATA, {24'h0, tbl[7'(126 + i)]});
      lut_op(1'b0);
    end
    rd(RTC_IDX_LUT_ADDR, 32'h81);
    wr(RTC_IDX_LUT_ADDR, 32'hfe);
    for (int i = 0; i < 3; i++) begin
      lut_op(1'b1);
      rd(RTC_IDX_LUT_DATA, {24'h0, tbl[7'(126 + i)]});
    end
    tw(7'h40, 8'($urandom));
    tw(7'h3f, 8'($urandom));
    tw(7'h01, 8'($urandom));
    wr(RTC_IDX_LUT_ADDR, 32'h40);
    lut_op(1'b1);
    rd(RTC_IDX_LUT_DATA, {24'h0, tbl[64]});
    rd(RTC_IDX_LUT_ADDR, 32'h40);
    wr(RTC_IDX_COMP_CTL, 32'h20);
    for (int i = 0; i < 6; i++) tmp(tc[i], 1'b1);
    rd(RTC_IDX_RATE, {13'h0, exp_rate});
    wr(RTC_IDX_COMP_CTL, 32'h0);
    tmp(tc[3], 1'b0);
    rd(RTC_IDX_RATE, {13'h0, exp_rate});
    tm.sec_toggle <= ~tm.sec_toggle;
    tick(4'b1100);
    tm.min_toggle <= ~tm.min_toggle;
    tick(4'b1010);
    tm.sec_toggle <= ~tm.sec_toggle;
    tm.min_toggle <= ~tm.min_toggle;
    tick(4'b1110);
    tmin = 6'($urandom_range(59, 1));
    thr = 5'($urandom_range(23, 1));
    wr(RTC_IDX_ALM_MIN, {26'h0, tmin});
    wr(RTC_IDX_ALM_HR, {27'h0, thr});
    rd(RTC_IDX_ALM_MIN, {26'h0, tmin});
    rd(RTC_IDX_ALM_HR, {27'h0, thr});
    // minutes alone must not raise the alarm
    tm.minutes <= tmin;
    repeat (12) @(posedge clk_i);
    tm.hours <= thr;
    tick(4'b1001);
    check("pending", 32'(rate_q.size() + irq_q.size()), 32'h0);
    summarize();
  end
endmodule

// [src/rtc_lut_alarm.sv]
// temperature compensation lookup table, rate output and tick/alarm interrupts
// ----------------------------------------------------------------
// Functional notes
// - clamp shifted temperature to -64..63, use as index
// - table reachable only through address, data, strobes
// - write strobe copies data byte, then self-clears
// - read strobe loads table entry into data register
// - auto-increment advances address after each strobe
// - without auto-increment strobes leave address alone
// - compensation off stops updates; table is storage
// - second and minute tick interrupt events
// - alarm when minutes and hours match targets
// - all three events share external interrupt six
// - six-bit target minutes register, reset zero
// - five-bit target hours register, reset zero
// - index is reading arithmetically shifted right two
// - signed entry plus 0x40000 loads 19-bit rate
// - rate updates after each completed temperature measurement
// - strobe stays set until done, then clears
// ----------------------------------------------------------------
//
// Decided for this implementation: the Wishbone register port.
module rtc_lut_alarm #(
  parameter int LUT_DEPTH = 128,
  parameter int ADR_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rtc_lut_pkg::rtc_wb_req_t wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic signed [rtc_lut_pkg::RTC_TEMP_W-1:0] die_temp_reading_i,
  input wire logic temp_done_i,
  input wire rtc_lut_pkg::rtc_time_t rtc_time_i,
  output logic [rtc_lut_pkg::RTC_RATE_W-1:0] rate_value_o,
  output logic rate_load_o,
  output logic second_tick_irq_o,
  output logic minute_tick_irq_o,
  output logic alarm_irq_o,
  output logic ext_int6_o
);
  import rtc_lut_pkg::*;

  localparam int TIME_W = $bits(rtc_time_t);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (LUT_DEPTH != 128) begin : g_depth_check
    $error("LUT_DEPTH must be 128: the index is a 7-bit signed clamp");
  end
  if (ADR_W != 16) begin : g_adr_check
    $error("ADR_W must be 16 to reach the register map");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] lut_mem [LUT_DEPTH];
  logic [6:0] lut_address_reg;
  logic lut_auto_increment_reg;
  logic [7:0] lut_data_reg;
  logic lut_write_strobe_reg;
  logic lut_read_strobe_reg;
  logic xtal_temp_comp_enable_reg;
  logic [RTC_MIN_W-1:0] alarm_target_minutes_reg;
  logic [CURRENT_HOURS_W-1:0] alarm_target_hours_reg;
  logic comp_pending_reg;
  logic [6:0] comp_index_reg;
  rtc_state_t state_reg;
  rtc_state_t state_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [RTC_RATE_W-1:0] rate_reg;
  logic rate_load_reg;

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  logic req_act;
  logic wr_act;
  logic [13:0] req_idx;
  logic wr_lane0;

  assign req_act = wb_req_i.cyc & wb_req_i.stb;
  assign req_idx = wb_req_i.adr[ADR_W-1:2];
  // writes land at the edge where ack is seen high
  assign wr_act = req_act & wb_req_i.we & ack_reg;
  assign wr_lane0 = wr_act & wb_req_i.sel[0];

  // table operations complete in one cycle of the op state
  logic op_write;
  logic op_read;
  logic op_done;
  assign op_write = (state_reg == RTC_ST_WRITE);
  assign op_read = (state_reg == RTC_ST_READ);
  assign op_done = op_write | op_read;

  // ----------------------------------------------------------------
  // sequencer: table port serves strobes and compensation in turn
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RTC_ST_IDLE: begin
        if (lut_write_strobe_reg) begin
          state_next = RTC_ST_WRITE;
        end else if (lut_read_strobe_reg) begin
          state_next = RTC_ST_READ;
        end else if (comp_pending_reg) begin
          state_next = RTC_ST_COMP;
        end
      end
      RTC_ST_WRITE: state_next = RTC_ST_IDLE;
      RTC_ST_READ: state_next = RTC_ST_IDLE;
      RTC_ST_COMP: state_next = RTC_ST_IDLE;
      default: state_next = RTC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= RTC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // index: shift then clamp
  // ----------------------------------------------------------------
  logic signed [8:0] temp_shifted;
  logic [6:0] temp_index;
  always_comb begin
    temp_shifted = 9'(die_temp_reading_i >>> RTC_SHIFT);
    if (temp_shifted > RTC_IDX_MAX) begin
      temp_index = RTC_IDX_MAX[6:0];
    end else if (temp_shifted < RTC_IDX_MIN) begin
      temp_index = RTC_IDX_MIN[6:0];
    end else begin
      temp_index = temp_shifted[6:0];
    end
  end

  // measurement finishing while the port is busy is held, not lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_pending_reg <= 1'b0;
      comp_index_reg <= RTC_ADDR_RST;
    end else if (temp_done_i && xtal_temp_comp_enable_reg) begin
      comp_pending_reg <= 1'b1;
      comp_index_reg <= temp_index;
    end else if (state_reg == RTC_ST_COMP || !xtal_temp_comp_enable_reg) begin
      comp_pending_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // table storage: battery-backed, so no reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (op_write) begin
      lut_mem[lut_address_reg] <= lut_data_reg;
    end
  end

  // ----------------------------------------------------------------
  // rate value
  // ----------------------------------------------------------------
  logic [7:0] comp_byte;
  assign comp_byte = lut_mem[comp_index_reg];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_reg <= RTC_RATE_NOMINAL;
      rate_load_reg <= 1'b0;
    end else begin
      rate_load_reg <= (state_reg == RTC_ST_COMP);
      if (state_reg == RTC_ST_COMP) begin
        rate_reg <= RTC_RATE_NOMINAL + {{(RTC_RATE_W-8){comp_byte[7]}}, comp_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // address / auto-increment register
  // ----------------------------------------------------------------
  // a software write in the same cycle as an increment wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_address_reg <= RTC_ADDR_RST;
      lut_auto_increment_reg <= 1'b0;
    end else if (wr_lane0 && req_idx == RTC_IDX_LUT_ADDR) begin
      lut_address_reg <= wb_req_i.dat[6:0];
      lut_auto_increment_reg <= wb_req_i.dat[RTC_BIT_AUTOINC];
    end else if (op_done && lut_auto_increment_reg) begin
      lut_address_reg <= lut_address_reg + RTC_ADDR_STEP;
    end
    // without auto-increment the address only moves by software
  end

  // ----------------------------------------------------------------
  // data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_data_reg <= RTC_BYTE_RST;
    end else if (op_read) begin
      lut_data_reg <= lut_mem[lut_address_reg];
    end else if (wr_lane0 && req_idx == RTC_IDX_LUT_DATA) begin
      lut_data_reg <= wb_req_i.dat[7:0];
    end
  end

  // ----------------------------------------------------------------
  // strobes: set by software, cleared on completion
  // ----------------------------------------------------------------
  logic strb_wr_hit;
  assign strb_wr_hit = wr_lane0 && (req_idx == RTC_IDX_LUT_STRB);

  // writing zero never cancels a strobe in flight; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_write_strobe_reg <= 1'b0;
      lut_read_strobe_reg <= 1'b0;
    end else begin
      if (strb_wr_hit && wb_req_i.dat[RTC_BIT_WR_STRB]) begin
        lut_write_strobe_reg <= 1'b1;
      end else if (op_write) begin
        lut_write_strobe_reg <= 1'b0;
      end
      if (strb_wr_hit && wb_req_i.dat[RTC_BIT_RD_STRB]) begin
        lut_read_strobe_reg <= 1'b1;
      end else if (op_read) begin
        lut_read_strobe_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and alarm targets
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_temp_comp_enable_reg <= 1'b0;
    end else if (wr_lane0 && req_idx == RTC_IDX_COMP_CTL) begin
      xtal_temp_comp_enable_reg <= wb_req_i.dat[RTC_BIT_COMP_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_target_minutes_reg <= '0;
      alarm_target_hours_reg <= '0;
    end else begin
      if (wr_lane0 && req_idx == RTC_IDX_ALM_MIN) begin
        alarm_target_minutes_reg <= wb_req_i.dat[RTC_MIN_W-1:0];
      end
      if (wr_lane0 && req_idx == RTC_IDX_ALM_HR) begin
        alarm_target_hours_reg <= wb_req_i.dat[CURRENT_HOURS_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (req_idx)
      RTC_IDX_LUT_ADDR: begin
        rd_mux[6:0] = lut_address_reg;
        rd_mux[RTC_BIT_AUTOINC] = lut_auto_increment_reg;
      end
      RTC_IDX_LUT_DATA: rd_mux[7:0] = lut_data_reg;
      RTC_IDX_LUT_STRB: begin
        rd_mux[RTC_BIT_WR_STRB] = lut_write_strobe_reg;
        rd_mux[RTC_BIT_RD_STRB] = lut_read_strobe_reg;
        rd_mux[RTC_BIT_BUSY] = (state_reg != RTC_ST_IDLE);
      end
      RTC_IDX_ALM_MIN: rd_mux[RTC_MIN_W-1:0] = alarm_target_minutes_reg;
      RTC_IDX_ALM_HR: rd_mux[CURRENT_HOURS_W-1:0] = alarm_target_hours_reg;
      RTC_IDX_COMP_CTL: rd_mux[RTC_BIT_COMP_EN] = xtal_temp_comp_enable_reg;
      RTC_IDX_RATE: rd_mux[RTC_RATE_W-1:0] = rate_reg;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= req_act & ~ack_reg;
      if (req_act && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // rtc-domain inputs: three stages, accepted once stages two and
  // three agree; the bus moves once a second so a whole-word match
  // keeps minutes and hours coherent
  // ----------------------------------------------------------------
  logic [TIME_W-1:0] sync1_reg;
  logic [TIME_W-1:0] sync2_reg;
  logic [TIME_W-1:0] sync3_reg;

  for (genvar gi = 0; gi < TIME_W; gi++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync1_reg[gi] <= 1'b0;
        sync2_reg[gi] <= 1'b0;
        sync3_reg[gi] <= 1'b0;
      end else begin
        sync1_reg[gi] <= rtc_time_i[gi];
        sync2_reg[gi] <= sync1_reg[gi];
        sync3_reg[gi] <= sync2_reg[gi];
      end
    end
  end

  rtc_time_t time_acc_reg;
  rtc_time_t time_prev_reg;
  logic match_prev_reg;
  logic alarm_match;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_acc_reg <= '0;
      time_prev_reg <= '0;
    end else begin
      if (sync2_reg == sync3_reg) begin
        time_acc_reg <= rtc_time_t'(sync2_reg);
      end
      time_prev_reg <= time_acc_reg;
    end
  end

  assign alarm_match = (time_acc_reg.minutes == alarm_target_minutes_reg) &&
                       (time_acc_reg.hours == alarm_target_hours_reg);

  // ----------------------------------------------------------------
  // interrupt pulses
  // ----------------------------------------------------------------
  logic sec_evt;
  logic min_evt;
  logic alm_evt;
  assign sec_evt = time_acc_reg.sec_toggle ^ time_prev_reg.sec_toggle;
  assign min_evt = time_acc_reg.min_toggle ^ time_prev_reg.min_toggle;
  // fires when the match becomes true, not while it stays true
  assign alm_evt = alarm_match & ~match_prev_reg;

  logic sec_irq_reg;
  logic min_irq_reg;
  logic alm_irq_reg;
  logic int6_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_prev_reg <= 1'b1;
      sec_irq_reg <= 1'b0;
      min_irq_reg <= 1'b0;
      alm_irq_reg <= 1'b0;
      int6_reg <= 1'b0;
    end else begin
      match_prev_reg <= alarm_match;
      sec_irq_reg <= sec_evt;
      min_irq_reg <= min_evt;
      alm_irq_reg <= alm_evt;
      int6_reg <= sec_evt | min_evt | alm_evt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign rate_value_o = rate_reg;
  assign rate_load_o = rate_load_reg;
  assign second_tick_irq_o = sec_irq_reg;
  assign minute_tick_irq_o = min_irq_reg;
  assign alarm_irq_o = alm_irq_reg;
  assign ext_int6_o = int6_reg;

endmodule

// [src/rtc_lut_pkg.sv]
// constants and carrier types for the temperature lookup and alarm block
package rtc_lut_pkg;

  // ----------------------------------------------------------------
  // register map (register index; byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [13:0] RTC_IDX_LUT_ADDR = 14'h2887;
  localparam logic [13:0] RTC_IDX_LUT_DATA = 14'h2888;
  localparam logic [13:0] RTC_IDX_LUT_STRB = 14'h2889;
  localparam logic [13:0] RTC_IDX_ALM_MIN = 14'h289e;
  localparam logic [13:0] RTC_IDX_ALM_HR = 14'h289f;
  localparam logic [13:0] RTC_IDX_COMP_CTL = 14'h28a0;
  localparam logic [13:0] RTC_IDX_RATE = 14'h28a1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RTC_BIT_AUTOINC = 7;
  localparam int RTC_BIT_WR_STRB = 0;
  localparam int RTC_BIT_RD_STRB = 1;
  localparam int RTC_BIT_BUSY = 2;
  localparam int RTC_BIT_COMP_EN = 5;

  // ----------------------------------------------------------------
  // widths, reset values, limits
  // ----------------------------------------------------------------
  localparam int RTC_MIN_W = 6;
  localparam int CURRENT_HOURS_W = 5;
  localparam int RTC_TEMP_W = 11;
  localparam int RTC_RATE_W = 19;
  localparam int RTC_SHIFT = 2;
  localparam logic [RTC_RATE_W-1:0] RTC_RATE_NOMINAL = 19'h40000;
  localparam logic signed [8:0] RTC_IDX_MAX = 9'sd63;
  localparam logic signed [8:0] RTC_IDX_MIN = -9'sd64;
  localparam logic [7:0] RTC_BYTE_RST = 8'h00;
  localparam logic [6:0] RTC_ADDR_RST = 7'h00;
  localparam logic [6:0] RTC_ADDR_STEP = 7'h01;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rtc_wb_req_t;

  typedef struct packed {
    logic sec_toggle;
    logic min_toggle;
    logic [RTC_MIN_W-1:0] minutes;
    logic [CURRENT_HOURS_W-1:0] hours;
  } rtc_time_t;

  typedef enum logic [3:0] {
    RTC_ST_IDLE = 4'b0001,
    RTC_ST_WRITE = 4'b0010,
    RTC_ST_READ = 4'b0100,
    RTC_ST_COMP = 4'b1000
  } rtc_state_t;

endpackage
